// ===== hdl/bl_cfg_pkg.sv
// Package with register map, field positions, resets and timing for the configuration bank.
package bl_cfg_pkg;
    localparam logic [7:0] OFS_LED_CURRENT_LOW       = 8'ha0;
    localparam logic [7:0] OFS_LED_CURRENT_HIGH      = 8'ha1;
    localparam logic [7:0] OFS_SOURCE_SELECT         = 8'ha2;
    localparam logic [7:0] OFS_TRANSITION_SHAPING    = 8'ha3;
    localparam logic [7:0] OFS_DIMMING_MIX_DITHER    = 8'ha4;
    localparam logic [7:0] OFS_PHASE_DIM_FREQUENCY   = 8'ha5;
    localparam logic [7:0] OFS_BOOST_FREQUENCY_SELECT_VOLTAGE    = 8'ha6;
    localparam logic [7:0] OFS_BOOST_DRIVE_LIMIT     = 8'ha7;
    localparam logic [7:0] OFS_BOOST_MAX_JUMP        = 8'ha9;
    localparam logic [7:0] OFS_SPREAD_HEADROOM       = 8'haa;
    localparam logic [7:0] OFS_ADAPTIVE_STEPS_FAULT  = 8'hae;
    localparam int         NUM_REGS                  = 11;
    localparam logic [7:0] REG_RESET                 = 8'h00;
    localparam logic [7:0] UNMAPPED_READ             = 8'h00;
    localparam int POS_LOW_STANDBY   = 7;
    localparam int POS_BACKLIGHT_ON  = 3;
    localparam int POS_RES_SCALE     = 2;
    localparam int POS_BOOST_PIN     = 1;
    localparam int POS_DIM_PIN       = 0;
    localparam int POS_SLOPE         = 4;
    localparam int POS_FILTER        = 2;
    localparam int POS_SWITCH_POINT  = 4;
    localparam int POS_DITHER_ALWAYS = 2;
    localparam int POS_DITHER_DEPTH  = 0;
    localparam int POS_PHASE         = 4;
    localparam int POS_DIM_FREQ      = 0;
    localparam int POS_BOOST_FREQUENCY_SELECT    = 6;
    localparam int POS_BOOST_VOLT    = 0;
    localparam int POS_JUMP_EN       = 4;
    localparam int POS_JUMP_TH       = 2;
    localparam int POS_JUMP_V        = 0;
    localparam int POS_ADAPTIVE      = 3;
    localparam int POS_STEP_UP       = 6;
    localparam int POS_HEADROOM_LOWER_SIZE       = 4;
    localparam int  STANDBY_TIMEOUT_MS = 50;
    localparam int  CLK_KHZ            = 125000;
    localparam int  STANDBY_CYCLES     = STANDBY_TIMEOUT_MS * CLK_KHZ;
    localparam int  DIM_PERIOD_CYCLES  = 1024;
    localparam int  SLOPE_UNIT_CYCLES  = 256;
    localparam logic [11:0] CURRENT_FULL = 12'hfff;
    localparam logic [3:0] SWITCH_ALL_CURRENT = 4'h0;
    localparam logic [3:0] SWITCH_ALL_PWM     = 4'hb;
    typedef enum logic [1:0] {BOOST_312K, BOOST_625K, BOOST_1250K, BOOST_UNDEF} boost_frequency_select_t;
    typedef enum logic [1:0] {DIM_CURRENT, DIM_MIXED, DIM_PWM} dim_mode_t;
endpackage : bl_cfg_pkg

// ===== hdl/cfg_mem_if.sv
// Interface carrying the write and read port of the register storage.
`timescale 1ns/1ps
`default_nettype none
interface cfg_mem_if;
    logic       we;
    logic [3:0] waddr;
    logic [7:0] wdata;
    logic [3:0] raddr;
    logic [7:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : cfg_mem_if
`default_nettype wire

// ===== hdl/cfg_store.sv
// Register storage with registered read data and flat view of every word.
`timescale 1ns/1ps
`default_nettype none
module cfg_store
    import bl_cfg_pkg::*;
#(
    parameter int N = NUM_REGS
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    cfg_mem_if.mem            port,
    output logic [N*8-1:0]    words
);
    logic [7:0] mem_q [N];
    wire  [N*8-1:0] flat;
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_word
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    mem_q[i] <= REG_RESET;
                end else if (port.we && port.waddr == 4'(i)) begin
                    mem_q[i] <= port.wdata;
                end
            end
            assign flat[i*8 +: 8] = mem_q[i];
        end
    endgenerate
    assign words = flat;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            port.rdata <= REG_RESET;
        end else begin
            port.rdata <= (int'(port.raddr) < N) ? mem_q[port.raddr] : UNMAPPED_READ;
        end
    end
endmodule : cfg_store
`default_nettype wire

// ===== hdl/backlight_config_registers.sv
// Configuration register bank of a six-channel backlight driver and the decode it steers.
`timescale 1ns/1ps
`default_nettype none
module backlight_config_registers
    import bl_cfg_pkg::*;
#(
    parameter int STANDBY_TIMEOUT = STANDBY_CYCLES,
    parameter int PERIOD          = DIM_PERIOD_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        dim_input,
    input  wire logic        host_brightness_enable,
    input  wire logic [1:0]  pin_boost_frequency_select,
    input  wire logic [3:0]  pin_dim_freq,
    input  wire logic [11:0] target_level,
    output logic [11:0]      current_code,
    output logic             resistor_scale_enable,
    output logic [2:0]       max_current_select,
    output logic             standby,
    output logic             backlight_run,
    output logic [1:0]       boost_frequency_select,
    output logic [3:0]       dim_frequency_select,
    output logic [1:0]       dim_resolution,
    output logic [11:0]      shaped_level,
    output logic [1:0]       smoothing,
    output logic [1:0]       dim_mode,
    output logic [3:0]       dim_switch_point,
    output logic             dither_active,
    output logic [1:0]       dither_depth,
    output logic [5:0]       driver_on,
    output logic [5:0]       boost_voltage_code,
    output logic             adaptive_enable,
    output logic [1:0]       headroom_raise_size,
    output logic [1:0]       headroom_lower_size,
    output logic             jump_enable,
    output logic [1:0]       jump_threshold,
    output logic [1:0]       jump_voltage_step
);
    // ------------------------------------------------------------------
    // Register bus and storage
    // ------------------------------------------------------------------
    cfg_mem_if mem ();
    logic [NUM_REGS*8-1:0] words;
    logic [3:0]  idx;
    logic        hit;

    assign hit = (reg_addr == OFS_LED_CURRENT_LOW) || (reg_addr == OFS_LED_CURRENT_HIGH)
              || (reg_addr == OFS_SOURCE_SELECT) || (reg_addr == OFS_TRANSITION_SHAPING)
              || (reg_addr == OFS_DIMMING_MIX_DITHER) || (reg_addr == OFS_PHASE_DIM_FREQUENCY)
              || (reg_addr == OFS_BOOST_FREQUENCY_SELECT_VOLTAGE) || (reg_addr == OFS_BOOST_DRIVE_LIMIT)
              || (reg_addr == OFS_BOOST_MAX_JUMP) || (reg_addr == OFS_SPREAD_HEADROOM)
              || (reg_addr == OFS_ADAPTIVE_STEPS_FAULT);
    assign idx = (reg_addr == OFS_BOOST_MAX_JUMP)       ? 4'h8 :
                 (reg_addr == OFS_SPREAD_HEADROOM)      ? 4'h9 :
                 (reg_addr == OFS_ADAPTIVE_STEPS_FAULT) ? 4'ha :
                 reg_addr[3:0];
    assign mem.we    = reg_wr && hit;
    assign mem.waddr = idx;
    assign mem.wdata = reg_wdata;
    assign mem.raddr = hit ? idx : 4'hf;
    assign reg_rdata = mem.rdata;

    cfg_store #(.N(NUM_REGS)) u_store (
        .core_clk (core_clk),
        .rst      (rst),
        .port     (mem),
        .words    (words)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    wire [7:0] r_low   = words[0*8 +: 8];
    wire [7:0] r_high  = words[1*8 +: 8];
    wire [7:0] r_src   = words[2*8 +: 8];
    wire [7:0] r_shape = words[3*8 +: 8];
    wire [7:0] r_mix   = words[4*8 +: 8];
    wire [7:0] r_phase = words[5*8 +: 8];
    wire [7:0] r_boost = words[6*8 +: 8];
    wire [7:0] r_jump  = words[8*8 +: 8];
    wire [7:0] r_adapt = words[9*8 +: 8];
    wire [7:0] r_steps = words[10*8 +: 8];

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    // Code assembly.
    assign current_code          = {r_high[3:0], r_low};
    assign max_current_select    = r_high[6:4];
    assign resistor_scale_enable = r_src[POS_RES_SCALE];
    assign boost_frequency_select = r_src[POS_BOOST_PIN] ? pin_boost_frequency_select
                                                         : r_boost[POS_BOOST_FREQUENCY_SELECT +: 2];
    assign dim_frequency_select  = r_src[POS_DIM_PIN] ? pin_dim_freq : r_phase[POS_DIM_FREQ +: 4];
    // Resolution by frequency band: 0 is 10-bit, 1 is 9-bit, 2 is 8-bit.
    assign dim_resolution = (dim_frequency_select < 4'h5) ? 2'd0 :
                            (dim_frequency_select < 4'hc) ? 2'd1 : 2'd2;
    assign smoothing        = r_shape[POS_FILTER +: 2];
    assign dim_switch_point = r_mix[POS_SWITCH_POINT +: 4];
    assign dim_mode = (dim_switch_point == SWITCH_ALL_CURRENT) ? 2'(DIM_CURRENT) :
                      (dim_switch_point >= SWITCH_ALL_PWM)     ? 2'(DIM_PWM) : 2'(DIM_MIXED);
    assign dither_depth     = r_mix[POS_DITHER_DEPTH +: 2];
    assign boost_voltage_code = r_boost[POS_BOOST_VOLT +: 6];
    assign adaptive_enable     = r_adapt[POS_ADAPTIVE];
    assign headroom_raise_size = r_steps[POS_STEP_UP +: 2];
    assign headroom_lower_size = r_steps[POS_HEADROOM_LOWER_SIZE +: 2];
    assign jump_enable       = r_jump[POS_JUMP_EN];
    assign jump_threshold    = r_jump[POS_JUMP_TH +: 2];
    assign jump_voltage_step = r_jump[POS_JUMP_V +: 2];

    // ------------------------------------------------------------------
    // Low-input standby timer
    // ------------------------------------------------------------------
    logic [31:0] low_cnt_q;
    logic        standby_q;
    always_ff @(posedge core_clk) begin
        if (rst || dim_input || !r_high[POS_LOW_STANDBY]) begin
            low_cnt_q <= 32'h0;
            standby_q <= 1'b0;
        end else if (low_cnt_q >= 32'(STANDBY_TIMEOUT - 1)) begin
            standby_q <= 1'b1;
        end else begin
            low_cnt_q <= low_cnt_q + 32'h1;
        end
    end
    assign standby = standby_q;
    // Backlight-on bit or host enable input runs the backlight outside standby.
    assign backlight_run = !standby_q && (r_src[POS_BACKLIGHT_ON] || host_brightness_enable);

    // ------------------------------------------------------------------
    // Slope ramp
    // ------------------------------------------------------------------
    logic [11:0] level_q;
    logic [11:0] ramp_cnt_q;
    logic [15:0] ramp_len;
    logic        in_transition;
    assign ramp_len      = 16'(SLOPE_UNIT_CYCLES) << r_shape[POS_SLOPE +: 3];
    assign in_transition = (level_q != target_level);
    // Zero slope is immediate, else one step per interval.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            level_q    <= 12'h0;
            ramp_cnt_q <= 12'h0;
        end else if (r_shape[POS_SLOPE +: 3] == 3'd0) begin
            level_q    <= target_level;
            ramp_cnt_q <= 12'h0;
        end else if (in_transition && ramp_cnt_q >= 12'(ramp_len >> 4)) begin
            ramp_cnt_q <= 12'h0;
            level_q    <= (level_q < target_level) ? level_q + 12'h1 : level_q - 12'h1;
        end else if (in_transition) begin
            ramp_cnt_q <= ramp_cnt_q + 12'h1;
        end
    end
    assign shaped_level = level_q;
    assign dither_active = (dither_depth != 2'd0)
                        && (r_mix[POS_DITHER_ALWAYS] || in_transition);

    // ------------------------------------------------------------------
    // Phase layout over the dimming period
    // ------------------------------------------------------------------
    logic [15:0] period_q;
    wire  [5:0]  drv_all;
    wire  [2:0]  layout = r_phase[POS_PHASE +: 3];
    always_ff @(posedge core_clk) begin
        if (rst || period_q >= 16'(PERIOD - 1)) begin
            period_q <= 16'h0;
        end else begin
            period_q <= period_q + 16'h1;
        end
    end

    function automatic logic [15:0] offset_of(input logic [2:0] lay, input int ch);
        int phases;
        int slot;
        phases = 6;
        slot   = ch;
        case (lay)
            3'd0: begin phases = 6; slot = ch; end
            3'd1: begin phases = 5; slot = ch; end
            3'd2: begin phases = 4; slot = ch; end
            3'd3: begin phases = 3; slot = ch; end
            3'd4: begin phases = 2; slot = ch; end
            3'd5: begin phases = 3; slot = ch / 2; end
            3'd6: begin phases = 2; slot = ch / 3; end
            default: begin phases = 1; slot = 0; end
        endcase
        return 16'((PERIOD * slot) / phases);
    endfunction

    function automatic logic used_of(input logic [2:0] lay, input int ch);
        return (lay >= 3'd5) || (ch < 6 - int'(lay));
    endfunction

    genvar c;
    generate
        for (c = 0; c < 6; c++) begin : g_drv
            logic on_q;
            // Fixed delay per phase within the period.
            always_ff @(posedge core_clk) begin
                if (rst || !used_of(layout, c) || !backlight_run) begin
                    on_q <= 1'b0;
                end else if (period_q == offset_of(layout, c)) begin
                    on_q <= 1'b1;
                end else if (period_q == 16'((offset_of(layout, c)
                                 + 16'(level_q >> 2)) % PERIOD)) begin
                    on_q <= 1'b0;
                end
            end
            assign drv_all[c] = on_q;
        end
    endgenerate
    assign driver_on = drv_all;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_code_assembly: assert property (@(posedge core_clk) disable iff (rst)
        $past(reg_wr) && $past(reg_addr) == OFS_LED_CURRENT_LOW |-> current_code[7:0] == $past(reg_wdata))
        else $error("current code low byte not taken");
    a_scale_select: assert property (@(posedge core_clk) disable iff (rst)
        $past(reg_wr) && $past(reg_addr) == OFS_SOURCE_SELECT
            |-> resistor_scale_enable == $past(reg_wdata[POS_RES_SCALE]))
        else $error("resistor scale bit not taken");
    a_standby_clear: assert property (@(posedge core_clk) disable iff (rst)
        dim_input |=> !standby)
        else $error("standby held with input high");
    a_boost_pin: assert property (@(posedge core_clk) disable iff (rst)
        r_src[POS_BOOST_PIN] |-> boost_frequency_select == pin_boost_frequency_select)
        else $error("boost frequency not from pin");
    a_dim_pin: assert property (@(posedge core_clk) disable iff (rst)
        !r_src[POS_DIM_PIN] |-> dim_frequency_select == r_phase[3:0])
        else $error("dimming frequency not from field");
    a_slope_zero: assert property (@(posedge core_clk) disable iff (rst)
        r_shape[6:4] == 3'd0 && $stable(r_shape) |=> shaped_level == $past(target_level))
        else $error("zero slope not immediate");
    a_mode_pwm: assert property (@(posedge core_clk) disable iff (rst)
        dim_switch_point == SWITCH_ALL_PWM |-> dim_mode == 2'(DIM_PWM))
        else $error("switch point all pwm wrong");
    a_dither_off: assert property (@(posedge core_clk) disable iff (rst)
        dither_depth == 2'd0 |-> !dither_active)
        else $error("dither active at zero depth");
    a_unused_off: assert property (@(posedge core_clk) disable iff (rst)
        layout == 3'd4 |=> driver_on[5:2] == 4'h0)
        else $error("unused driver on");

    // ------------------------------------------------------------------
    // Standby, drive, readback, decode and ramp checks
    // ------------------------------------------------------------------
    // Sequences name the steps of the longer checks.
    sequence s_read_asked;
        reg_rd;
    endsequence
    sequence s_read_answered;
        reg_rvalid;
    endsequence
    sequence s_long_low;
        r_high[POS_LOW_STANDBY] && !dim_input && standby;
    endsequence
    sequence s_ramp_running;
        r_shape[POS_SLOPE +: 3] != 3'd0;
    endsequence
    a_read_answer: assert property (@(posedge core_clk) disable iff (rst)
        s_read_asked |=> s_read_answered)
        else $error("read answer missing");
    a_read_spurious: assert property (@(posedge core_clk) disable iff (rst)
        !reg_rd |=> !reg_rvalid)
        else $error("read answer without request");
    a_standby_held: assert property (@(posedge core_clk) disable iff (rst)
        s_long_low |=> standby)
        else $error("standby dropped while input low");
    a_standby_gate: assert property (@(posedge core_clk) disable iff (rst)
        !r_high[POS_LOW_STANDBY] |=> !standby)
        else $error("standby without enable bit");
    a_run_standby: assert property (@(posedge core_clk) disable iff (rst)
        standby |-> !backlight_run)
        else $error("backlight running in standby");
    a_boost_field: assert property (@(posedge core_clk) disable iff (rst)
        !r_src[POS_BOOST_PIN] |-> boost_frequency_select == r_boost[POS_BOOST_FREQUENCY_SELECT +: 2])
        else $error("boost frequency not from field");
    a_res_low: assert property (@(posedge core_clk) disable iff (rst)
        dim_frequency_select >= 4'hc |-> dim_resolution == 2'd2)
        else $error("high frequency resolution wrong");
    a_res_top: assert property (@(posedge core_clk) disable iff (rst)
        dim_frequency_select < 4'h5 |-> dim_resolution == 2'd0)
        else $error("low frequency resolution wrong");
    a_mode_current: assert property (@(posedge core_clk) disable iff (rst)
        dim_switch_point == SWITCH_ALL_CURRENT |-> dim_mode == 2'(DIM_CURRENT))
        else $error("switch point all current wrong");
    a_dither_steady: assert property (@(posedge core_clk) disable iff (rst)
        dither_depth != 2'd0 && r_mix[POS_DITHER_ALWAYS] |-> dither_active)
        else $error("dither_always not active");
    a_ramp_step: assert property (@(posedge core_clk) disable iff (rst)
        s_ramp_running |=> shaped_level == $past(shaped_level)
            || shaped_level == $past(shaped_level) + 12'h1
            || shaped_level == $past(shaped_level) - 12'h1)
        else $error("ramp moved by more than one step");
    a_drivers_dark: assert property (@(posedge core_clk) disable iff (rst)
        !backlight_run |=> driver_on == 6'h00)
        else $error("driver on while backlight stopped");
endmodule : backlight_config_registers
`default_nettype wire

// ===== bench/dim_source_model.sv
// Model of the dimming input source that drives the configuration bank.
`timescale 1ns/1ps
`default_nettype none
module dim_source_model (
    input  wire logic       core_clk,
    input  wire logic [1:0] mode,
    input  wire logic [3:0] duty,
    output logic            dim_input
);
    logic [3:0] phase_q;
    // ------------------------------------------------------------
    // Waveform
    // ------------------------------------------------------------
    // Mode 0 holds the input low, 1 holds it high, 2 sends a 16-cycle pulse train.
    initial begin
        phase_q   = 4'h0;
        dim_input = 1'b0;
    end
    always @(posedge core_clk) begin
        phase_q   <= #1 phase_q + 4'h1;
        dim_input <= #1 (mode == 2'h1) | ((mode == 2'h2) & (phase_q < duty));
    end
endmodule : dim_source_model
`default_nettype wire

// ===== bench/backlight_config_registers_bench.sv
// Self-checking bench for the backlight configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module backlight_config_registers_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int STBY = 100;
    localparam int PER  = 64;
    logic        core_clk, rst, reg_wr, reg_rd, reg_rvalid, dim_input, host_en, standby;
    logic        resistor_scale_enable, backlight_run, dither_active, adaptive_enable, jump_enable;
    logic [1:0]  boost_frequency_select, dim_resolution, smoothing, dim_mode, dither_depth;
    logic [1:0]  headroom_raise_size, headroom_lower_size, jump_threshold, jump_voltage_step;
    logic [1:0]  pin_boost_frequency_select, src_mode;
    logic [2:0]  max_current_select;
    logic [3:0]  dim_frequency_select, dim_switch_point, pin_dim_freq, src_duty, dsel;
    logic [5:0]  driver_on, boost_voltage_code, seen_on;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, rv;
    logic [11:0] current_code, shaped_level, target_level;
    logic [7:0]  s [11];
    logic [7:0]  ofs [11] = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha9,
                              8'haa, 8'hae};
    int          n_fail, samples_checked, k, n;
    int          seed = 32'h619b;

    backlight_config_registers #(.STANDBY_TIMEOUT(STBY), .PERIOD(PER)) i_backlight_config_registers (
        .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .dim_input(dim_input), .host_brightness_enable(host_en), .pin_boost_frequency_select(pin_boost_frequency_select),
        .pin_dim_freq(pin_dim_freq), .target_level(target_level), .current_code(current_code),
        .resistor_scale_enable(resistor_scale_enable), .max_current_select(max_current_select),
        .standby(standby), .backlight_run(backlight_run),
        .boost_frequency_select(boost_frequency_select), .dim_frequency_select(dim_frequency_select),
        .dim_resolution(dim_resolution), .shaped_level(shaped_level), .smoothing(smoothing),
        .dim_mode(dim_mode), .dim_switch_point(dim_switch_point), .dither_active(dither_active),
        .dither_depth(dither_depth), .driver_on(driver_on), .boost_voltage_code(boost_voltage_code),
        .adaptive_enable(adaptive_enable), .headroom_raise_size(headroom_raise_size),
        .headroom_lower_size(headroom_lower_size), .jump_enable(jump_enable),
        .jump_threshold(jump_threshold), .jump_voltage_step(jump_voltage_step));

    dim_source_model i_dim_source_model (.core_clk(core_clk), .mode(src_mode), .duty(src_duty),
        .dim_input(dim_input));

    always #4 core_clk = ~core_clk;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = v;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_rd   = 1'b1;
        reg_addr = a;
        tick();
        reg_rd = 1'b0;
        check(reg_rvalid, 1'b1, "rvalid");
        v = reg_rdata;
        tick();
    endtask : rd
    function automatic logic [1:0] exp_res(input logic [3:0] sel);
        return (sel < 4'h5) ? 2'h0 : (sel < 4'hc) ? 2'h1 : 2'h2;
    endfunction : exp_res
    function automatic logic [1:0] exp_mode(input logic [3:0] sp);
        return (sp == 4'h0) ? 2'h0 : (sp == 4'hb) ? 2'h2 : 2'h1;
    endfunction : exp_mode
    task automatic check_decode;
        dsel = s[2][0] ? pin_dim_freq : s[5][3:0];
        check(current_code, {s[1][3:0], s[0]}, "code");
        check(max_current_select, s[1][6:4], "max");
        check(resistor_scale_enable, s[2][2], "rscale");
        check(backlight_run, s[2][3] | host_en, "run");
        check(boost_frequency_select, s[2][1] ? pin_boost_frequency_select : s[6][7:6], "bfreq");
        check(dim_frequency_select, dsel, "dfreq");
        check(dim_resolution, exp_res(dsel), "res");
        check(smoothing, s[3][3:2], "smooth");
        check(dim_switch_point, s[4][7:4], "switch");
        if (s[4][7:4] <= 4'hb) check(dim_mode, exp_mode(s[4][7:4]), "mode");
        check(dither_depth, s[4][1:0], "depth");
        check(boost_voltage_code, s[6][5:0], "boost_voltage_code");
        check({adaptive_enable, headroom_raise_size, headroom_lower_size},
              {s[9][3], s[10][7:4]}, "adaptive");
        check({jump_enable, jump_threshold, jump_voltage_step}, s[8][4:0], "jump");
    endtask : check_decode
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {core_clk, reg_wr, reg_rd, reg_addr, reg_wdata, host_en, target_level} = '0;
        {pin_boost_frequency_select, pin_dim_freq, src_mode, src_duty} = '0;
        rst = 1'b1;
        repeat (20) @(posedge core_clk);
        #1;
        rst = 1'b0;
        begin : scenarios
        for (int i = 0; i < 11; i++) begin
            s[i] = 8'h00;
            rd(ofs[i], rv);
            check(rv, 8'h00, "reset value");
        end
        wr(8'ha8, 8'hff);
        wr(8'haf, 8'hff);
        rd(8'ha8, rv);
        check(rv, 8'h00, "unmapped");
        rd(8'ha9, rv);
        check(rv, 8'h00, "no alias");
        src_mode = 2'h2;
        src_duty = 4'h8;
        for (int it = 0; it < 60; it++) begin
            k = {$random(seed)} % 11;
            d = 8'($random(seed));
            {pin_boost_frequency_select, pin_dim_freq, host_en} = 7'($random(seed));
            wr(ofs[k], d);
            s[k] = d;
            rd(ofs[k], rv);
            check(rv, s[k], "readback");
            check(standby, 1'b0, "pulsed input");
            check_decode();
        end
        host_en = 1'b1;
        wr(8'ha3, 8'h00);
        wr(8'ha4, 8'h01);
        target_level = 12'h3c5;
        tick();
        check(shaped_level, 12'h3c5, "slope zero");
        check(dither_active, 1'b0, "dither idle");
        wr(8'ha3, 8'h10);
        target_level = 12'h3d9;
        tick();
        check(shaped_level != target_level, 1'b1, "ramping");
        check(dither_active, 1'b1, "dither ramp");
        for (n = 0; n < 3000 && shaped_level !== target_level; n++) tick();
        if (n >= 3000) begin
            n_fail++;
            disable scenarios;
        end
        check(dither_active, 1'b0, "dither done");
        wr(8'ha4, 8'h05);
        check(dither_active, 1'b1, "dither always");
        wr(8'ha4, 8'h04);
        check(dither_active, 1'b0, "depth off");
        wr(8'ha3, 8'h00);
        target_level = 12'h080;
        for (int c = 0; c < 8; c++) begin
            wr(8'ha5, 8'(c << 4));
            seen_on = 6'h00;
            for (int t = 0; t < 2 * PER; t++) begin
                tick();
                seen_on = seen_on | driver_on;
                // Drivers realign only after the first period start in the new layout.
                if (c == 7 && t >= PER)
                    check(driver_on == 6'h00 || driver_on == 6'h3f, 1'b1, "phase");
            end
            check(seen_on, (c <= 4) ? (6'h3f >> c) : 6'h3f, "drivers used");
        end
        host_en = 1'b0;
        src_mode = 2'h1;
        wr(8'ha2, 8'h08);
        wr(8'ha1, 8'h80);
        src_mode = 2'h0;
        for (n = 0; n < 400 && standby !== 1'b1; n++) tick();
        if (n >= 400) begin
            n_fail++;
            disable scenarios;
        end
        check(n >= STBY - 1 && n <= STBY + 4, 1'b1, "standby time");
        check(backlight_run, 1'b0, "run in standby");
        src_mode = 2'h1;
        repeat (3) tick();
        check(standby, 1'b0, "wake");
        check(backlight_run, 1'b1, "run awake");
        wr(8'ha1, 8'h00);
        src_mode = 2'h0;
        repeat (STBY + 20) tick();
        check(standby, 1'b0, "standby off");
        end : scenarios
        conclude();
    end
endmodule : backlight_config_registers_bench
`default_nettype wire
